/* memory_interface_decode.sv */
`timescale 1ns/10ps
// memory interface decode: pin selects, on-board enables, bus control, clock, reset
// Operation
// - output clock is oscillator divided by 1..4 from two select bits
// - each multipurpose pin individually picks port or chip enable
// - role switch and function select both on give I/O port, otherwise decoded chip select
// - pin chip enables decoded by first two decode arrays
// - port address of a pin used as port matched in first two arrays
// - third array plus part of fourth give ROM, RAM, port enables
// - rest of fourth array gives receiver, driver, port clock, read drives
// - no_rom suppresses every ROM chip enable
// - no_ram suppresses RAM chip enable and RAM output drive
// - no_port suppresses port select, port write clock, port read drive
// - rom_size_sel held off selects larger ROM arrangement
// - external switch reset request resets system without power loss
// - reset logic active for RC or external source; crystal gives switch only
// - power-on reset output only when configured
// - data bus 8 bits, bidirectional, received and driven under control
// - oscillator timed by crystal, RC network or external clock
// - names ending in _n are asserted low
// - memory decodes need memory_or_io_sel 1, I/O decodes need 0
// - non-extended I/O uses two upper address bits as mode code only
module memory_interface_decode
	import memory_interface_pkg::*;
#(
	parameter int POR_COUNT = POR_CYCLES,
	// per-pin decode patterns: chip select match and mask on the address
	parameter logic [NUM_PINS*ADDR_W-1:0] PIN_MATCH = '0,
	parameter logic [NUM_PINS*ADDR_W-1:0] PIN_MASK = '0,
	parameter logic [NUM_PINS-1:0] PIN_IS_MEM = '1,
	// on-board ROM window: address bits above the ROM span
	parameter logic [ADDR_W-1:0] ROM_BASE = 15'h0000,
	parameter logic [ADDR_W-1:0] ROM_MASK = 15'h7000,
	parameter logic [ADDR_W-1:0] RAM_BASE = 15'h1000,
	parameter logic [ADDR_W-1:0] RAM_MASK = 15'h7F80,
	// port decode: mode code on the two upper address bits
	parameter logic [1:0] PORT_MODE = 2'h2
)(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire memory_interface_pkg::cpu_req_s cpu_req,
	input wire memory_interface_pkg::options_s options,
	input wire logic [NUM_PINS-1:0] pin_function_select,
	input wire logic [NUM_PINS-1:0] pin_role_switch,
	input wire logic ext_reset_request,
	input wire logic [DATA_W-1:0] data_bus_in,
	output logic [DATA_W-1:0] data_bus_out,
	output logic data_bus_oe_n,
	output logic [DATA_W-1:0] received_data,
	output logic [NUM_PINS-1:0] pin_chip_enable_n,
	output logic [NUM_PINS-1:0] pin_port_select_n,
	output memory_interface_pkg::enables_s enables,
	output logic clock_tick,
	output logic system_reset_out,
	output logic power_on_reset_out,
	input wire logic [DATA_W-1:0] internal_read_data
);
	import memory_interface_pkg::*;

	logic [2:0] rst_sync_reg;
	logic reset_pressed_reg;
	logic [POR_W-1:0] por_count_reg;
	logic por_active_reg;
	logic [NUM_PINS-1:0] pin_hit;
	logic [NUM_PINS-1:0] pin_as_port;
	logic [NUM_PINS-1:0] pin_ce_n_next;
	logic [NUM_PINS-1:0] pin_port_n_next;
	logic mem_cycle;
	logic io_cycle;
	logic rom_hit;
	logic ram_hit;
	logic port_hit;
	logic rom_en;
	logic ram_en;
	logic port_en;
	logic [NUM_ROM-1:0] rom_ce_n_next;
	logic [1:0] rom_index;
	logic reading;
	logic writing;
	enables_s enables_next;
	logic [1:0] div_ratio;
	logic reset_logic_used;

	// memory and I/O qualification on the request line
	assign mem_cycle = cpu_req.operation_request & cpu_req.memory_or_io_sel;
	assign io_cycle = cpu_req.operation_request & ~cpu_req.memory_or_io_sel;
	assign reading = ~cpu_req.read_write;
	assign writing = cpu_req.read_write & cpu_req.write_pulse_strobe;

	// first two arrays: each pin compares the address under its mask
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			pin_hit[i] = ((cpu_req.addr & PIN_MASK[i*ADDR_W +: ADDR_W])
				== (PIN_MATCH[i*ADDR_W +: ADDR_W] & PIN_MASK[i*ADDR_W +: ADDR_W]))
				& (PIN_IS_MEM[i] ? mem_cycle : io_cycle);
		end
	end

	// each pin picks its role on its own; both select lines must be on for port
	assign pin_as_port = pin_function_select & pin_role_switch;

	// route each hit to the chip enable or the port select, never both
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			pin_ce_n_next[i] = ~(pin_hit[i] & ~pin_as_port[i]);
			pin_port_n_next[i] = ~(pin_hit[i] & pin_as_port[i]);
		end
	end

	// third array: on-board memory windows
	assign rom_hit = mem_cycle & ((cpu_req.addr & ROM_MASK) == ROM_BASE);
	assign ram_hit = mem_cycle & ((cpu_req.addr & RAM_MASK) == RAM_BASE);
	// non-extended I/O: only the mode code is looked at
	assign port_hit = io_cycle
		& ({cpu_req.addr[ADDR_MODE_HI], cpu_req.addr[ADDR_MODE_LO]} == PORT_MODE);

	// options gate the sources; priority ROM over RAM over port keeps one driver
	assign rom_en = rom_hit & ~options.no_rom;
	assign ram_en = ram_hit & ~options.no_ram & ~rom_en;
	assign port_en = port_hit & ~options.no_port & ~rom_en & ~ram_en;

	// ROM bank select; the larger arrangement uses two address bits
	always_comb begin
		if (!options.rom_size_sel) begin
			rom_index = {cpu_req.addr[ROM_SEL_HI], cpu_req.addr[ROM_SEL_LO]};
		end else begin
			rom_index = {1'b0, cpu_req.addr[ROM_SEL_SMALL_HI]};
		end
		rom_ce_n_next = '1;
		if (rom_en) begin
			rom_ce_n_next[rom_index] = 1'b0;
		end
	end

	// fourth array: bus control from the selected source
	always_comb begin
		enables_next.rom_ce_n = rom_ce_n_next;
		enables_next.ram_ce_n = ~ram_en;
		enables_next.port_sel_n = ~port_en;
		enables_next.bus_drive_en_n = ~((rom_en | ram_en | port_en) & reading);
		enables_next.bus_receive_en_n = ~((ram_en | port_en) & cpu_req.read_write);
		enables_next.port_write_clk_n = ~(port_en & writing);
		enables_next.port_read_drive_n = ~(port_en & reading);
		enables_next.ram_read_drive_n = ~(ram_en & reading);
	end

	// registered enables: outputs settle one cycle after the request
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			enables <= '1;
			pin_chip_enable_n <= '1;
			pin_port_select_n <= '1;
		end else begin
			enables <= enables_next;
			pin_chip_enable_n <= pin_ce_n_next;
			pin_port_select_n <= pin_port_n_next;
		end
	end

	// data path: capture on receive, drive internal read data on drive
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			received_data <= '0;
			data_bus_out <= '0;
			data_bus_oe_n <= 1'b1;
		end else begin
			if (!enables_next.bus_receive_en_n) begin
				received_data <= data_bus_in;
			end
			data_bus_out <= internal_read_data;
			data_bus_oe_n <= enables_next.bus_drive_en_n;
		end
	end

	// clock divider: select bits map straight onto the ratio code
	assign div_ratio = {options.divider_select_high, options.divider_select_low};

	clock_divider u_clock_divider (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.ratio(div_ratio),
		.tick(clock_tick)
	);

	// the crystal, RC and external sources all feed core_clk; only reset differs
	assign reset_logic_used = (options.osc_source == OSC_RC)
		| (options.osc_source == OSC_EXTERNAL);

	// switch input comes from a pin: three stages, change counted when last two agree
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rst_sync_reg <= '0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[1:0], ext_reset_request};
		end
	end

	// debounced level of the switch closure
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reset_pressed_reg <= 1'b0;
		end else if (rst_sync_reg[1] == rst_sync_reg[2]) begin
			reset_pressed_reg <= rst_sync_reg[2];
		end
	end

	// power-on stretch after the core reset releases
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			por_count_reg <= '0;
			por_active_reg <= 1'b1;
		end else if (por_active_reg) begin
			if (por_count_reg == POR_W'(POR_COUNT - 1)) begin
				por_active_reg <= 1'b0;
			end else begin
				por_count_reg <= por_count_reg + POR_W'(1);
			end
		end
	end

	// system reset: switch always; power-on part only with the option and source
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			system_reset_out <= 1'b1;
			power_on_reset_out <= 1'b0;
		end else begin
			system_reset_out <= reset_pressed_reg
				| (por_active_reg & reset_logic_used & options.por_enable);
			power_on_reset_out <= por_active_reg & options.por_enable
				& reset_logic_used;
		end
	end
endmodule : memory_interface_decode

/* memory_interface_pkg.sv */
// package of constants and carriers for the memory interface decode block
package memory_interface_pkg;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int NUM_PINS = 8;
	localparam int NUM_ROM = 4;
	// address bit positions
	localparam int ADDR_MODE_HI = 14;
	localparam int ADDR_MODE_LO = 13;
	localparam int ROM_SEL_LO = 10;
	localparam int ROM_SEL_HI = 11;
	localparam int ROM_SEL_SMALL_HI = 10;
	// clock divider ratio encodings
	localparam logic [1:0] DIV_BY_1 = 2'h0;
	localparam logic [1:0] DIV_BY_2 = 2'h1;
	localparam logic [1:0] DIV_BY_3 = 2'h2;
	localparam logic [1:0] DIV_BY_4 = 2'h3;
	localparam logic [1:0] DIV_CNT_ZERO = 2'h0;
	localparam logic [1:0] DIV_CNT_ONE = 2'h1;
	// power-on reset stretch
	localparam int POR_TIME_NS = 1000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POR_W = 8;
	// oscillator source selection
	typedef enum logic [1:0] {
		OSC_CRYSTAL,
		OSC_RC,
		OSC_EXTERNAL
	} osc_source_e;
	// processor bus request as seen by the decoder
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic operation_request;
		logic write_pulse_strobe;
		logic read_write;
		logic memory_or_io_sel;
	} cpu_req_s;
	// option switches
	typedef struct packed {
		logic no_port;
		logic no_rom;
		logic no_ram;
		logic rom_size_sel;
		logic divider_select_low;
		logic divider_select_high;
		logic por_enable;
		osc_source_e osc_source;
	} options_s;
	// decoded enables, all active low
	typedef struct packed {
		logic [NUM_ROM-1:0] rom_ce_n;
		logic ram_ce_n;
		logic port_sel_n;
		logic bus_receive_en_n;
		logic bus_drive_en_n;
		logic port_write_clk_n;
		logic port_read_drive_n;
		logic ram_read_drive_n;
	} enables_s;
endpackage : memory_interface_pkg

/* clock_divider.sv */
`timescale 1ns/10ps
// divide-by-1..4 enable generator driven from the oscillator clock
module clock_divider
	import memory_interface_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [1:0] ratio,
	output logic tick
);
	logic [1:0] count_reg;
	logic [1:0] count_next;

	// count down from ratio; ratio value n divides by n+1
	always_comb begin
		if (count_reg == DIV_CNT_ZERO) begin
			count_next = ratio;
		end else begin
			count_next = count_reg - DIV_CNT_ONE;
		end
	end

	// counter state
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_reg <= DIV_CNT_ZERO;
		end else begin
			count_reg <= count_next;
		end
	end

	// tick marks the wrap; by-1 keeps it high every cycle
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tick <= 1'b0;
		end else begin
			tick <= (count_next == DIV_CNT_ZERO);
		end
	end
endmodule : clock_divider

/* memory_interface_properties.sv */
// port checker for the memory interface decode block
`timescale 1ns/10ps
module memory_interface_checker
	import memory_interface_pkg::*;
#(
	parameter int POR_COUNT = 4
)(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire memory_interface_pkg::cpu_req_s cpu_req,
	input wire memory_interface_pkg::options_s options,
	input wire logic [NUM_PINS-1:0] pin_function_select,
	input wire logic [NUM_PINS-1:0] pin_role_switch,
	input wire logic [DATA_W-1:0] data_bus_in,
	input wire logic data_bus_oe_n,
	input wire logic [DATA_W-1:0] received_data,
	input wire logic [NUM_PINS-1:0] pin_chip_enable_n,
	input wire memory_interface_pkg::enables_s enables,
	input wire logic clock_tick,
	input wire logic power_on_reset_out
);
	logic [POR_W-1:0] por_len_reg;
	// pulse length in a counter, since a long repetition is slow to unroll
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			por_len_reg <= '0;
		end else begin
			por_len_reg <= power_on_reset_out ? por_len_reg + POR_W'(1) : '0;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// memory read inside the default rom window
	sequence rom_rd_s;
		cpu_req.operation_request && cpu_req.memory_or_io_sel && !cpu_req.read_write
			&& cpu_req.addr[14:12] == 3'h0 && !options.no_rom;
	endsequence
	rom_off_a: assert property (options.no_rom |=> &enables.rom_ce_n)
		else $error("rom enable while rom disabled");
	ram_off_a: assert property (options.no_ram |=> enables.ram_ce_n && enables.ram_read_drive_n)
		else $error("ram enable while ram disabled");
	port_off_a: assert property (options.no_port |=> enables.port_sel_n
		&& enables.port_write_clk_n && enables.port_read_drive_n) else $error("port enable while off");
	one_source_a: assert property ($onehot0({!(&enables.rom_ce_n), !enables.ram_ce_n,
		!enables.port_sel_n})) else $error("two internal sources enabled");
	io_no_mem_a: assert property (!cpu_req.memory_or_io_sel |=> &enables.rom_ce_n && enables.ram_ce_n)
		else $error("memory enable on io access");
	rom_drive_a: assert property (rom_rd_s |=> !enables.bus_drive_en_n && !data_bus_oe_n)
		else $error("rom read without bus drive");
	port_write_a: assert property (cpu_req.operation_request && !cpu_req.memory_or_io_sel
		&& cpu_req.read_write && cpu_req.write_pulse_strobe && cpu_req.addr[14:13] == 2'h2
		&& !options.no_port |=> !enables.port_write_clk_n && received_data == $past(data_bus_in))
		else $error("port write not clocked");
	port_pin_a: assert property ((~pin_chip_enable_n
		& $past(pin_function_select & pin_role_switch)) == 8'h00) else $error("port pin as select");
	div_four_a: assert property (options.divider_select_low && options.divider_select_high
		&& clock_tick |=> !clock_tick [*3] ##1 clock_tick) else $error("divide by four period");
	por_len_a: assert property (por_len_reg <= POR_COUNT)
		else $error("power-on pulse too long");
	por_off_a: assert property (options.osc_source == OSC_CRYSTAL || !options.por_enable
		|=> !power_on_reset_out) else $error("power-on pulse not configured");
	cover property (!enables.port_write_clk_n);
	cover property (power_on_reset_out);
	cover property (!enables.ram_ce_n);
endmodule : memory_interface_checker

bind memory_interface_decode memory_interface_checker #(.POR_COUNT(POR_COUNT)) chk_u (
	.core_clk(core_clk), .sys_rst(sys_rst), .cpu_req(cpu_req), .options(options),
	.pin_function_select(pin_function_select), .pin_role_switch(pin_role_switch),
	.data_bus_in(data_bus_in), .data_bus_oe_n(data_bus_oe_n), .received_data(received_data),
	.pin_chip_enable_n(pin_chip_enable_n), .enables(enables), .clock_tick(clock_tick),
	.power_on_reset_out(power_on_reset_out));

/* cpu_bus_model.sv */
// processor side model: presents requests and owns its half of the data bus
`timescale 1ns/10ps
module cpu_bus_model
	import memory_interface_pkg::*;
(
	input wire logic core_clk,
	input wire memory_interface_pkg::cpu_req_s cmd,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [DATA_W-1:0] data_bus_out,
	input wire logic data_bus_oe_n,
	output memory_interface_pkg::cpu_req_s cpu_req,
	output logic [DATA_W-1:0] data_bus_in
);
	logic [DATA_W-1:0] last_reg;
	// request held as the bench set it after a falling edge
	assign cpu_req = cmd;
	// wire level; an undriven bus flips every cycle so stale data never matches
	always_comb begin
		if (cmd.operation_request && cmd.read_write) begin
			data_bus_in = wdata;
		end else if (!data_bus_oe_n) begin
			data_bus_in = data_bus_out;
		end else begin
			data_bus_in = ~last_reg;
		end
	end
	always_ff @(posedge core_clk) begin
		last_reg <= data_bus_in;
	end
endmodule : cpu_bus_model

/* memory_interface_decode_bench.sv */
// self-checking bench for the memory interface decode block
`timescale 1ns/10ps
module memory_interface_decode_bench;
	import memory_interface_pkg::*;
	logic core_clk = 1'b0, sys_rst = 1'b1, ext_rst = 1'b0, tick, sro, poro, oe_n;
	cpu_req_s cmd = '0, req;
	options_s opt;
	enables_s en;
	logic [7:0] fs = 8'hff, rs = 8'h08, wdata = 8'h00, ird = 8'h00, din, dout, rx, pce_n, pps_n;
	int bad_count = 0, checks = 0, cyc = 0;
	memory_interface_decode #(.POR_COUNT(4), .PIN_MASK({8{15'h7000}}),
		.PIN_MATCH({15'h7000, 15'h6000, 15'h5000, 15'h4000, 15'h3000, 15'h2000, 15'h1000, 15'h0000})
	) dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .cpu_req(req), .options(opt),
		.pin_function_select(fs), .pin_role_switch(rs), .ext_reset_request(ext_rst),
		.data_bus_in(din), .data_bus_out(dout), .data_bus_oe_n(oe_n), .received_data(rx),
		.pin_chip_enable_n(pce_n), .pin_port_select_n(pps_n), .enables(en), .clock_tick(tick),
		.system_reset_out(sro), .power_on_reset_out(poro), .internal_read_data(ird));
	cpu_bus_model cpu_u (.core_clk(core_clk), .cmd(cmd), .wdata(wdata), .data_bus_out(dout),
		.data_bus_oe_n(oe_n), .cpu_req(req), .data_bus_in(din));
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	// hang guard; the whole sequence needs well under a thousand cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// one processor operation, answer settled one cycle later
	task automatic op(input logic [14:0] a, input logic mem, input logic wr, input logic [7:0] d);
		@(negedge core_clk);
		cmd = '{addr: a, operation_request: 1'b1, write_pulse_strobe: wr, read_write: wr,
			memory_or_io_sel: mem};
		wdata = d;
		ird = d;
		@(negedge core_clk);
	endtask : op
	task automatic do_rst();
		sys_rst = 1'b1;
		repeat (5) @(negedge core_clk);
		sys_rst = 1'b0;
	endtask : do_rst
	task automatic t_mem();
		for (int k = 0; k < 4; k++) begin
			op({3'h0, k[1:0], 10'h155}, 1'b1, 1'b0, 8'h3c + 8'(k));
			chk("rom_ce_n", 8'(~(4'h1 << k)) & 8'h0f, 8'(en.rom_ce_n));
			chk("drive", 8'h00, 8'({oe_n, en.bus_drive_en_n}));
			chk("data_out", 8'h3c + 8'(k), dout);
		end
		op(15'h1000, 1'b1, 1'b0, 8'h77);
		chk("ram", 8'h01, 8'({en.ram_ce_n, en.ram_read_drive_n, &en.rom_ce_n}));
		op(15'h0000, 1'b0, 1'b0, 8'h00);
		chk("io_mem", 8'h03, 8'({&en.rom_ce_n, en.ram_ce_n}));
		op(15'h5fff, 1'b0, 1'b1, 8'ha5);
		chk("port_wr", 8'h00, 8'({en.port_sel_n, en.port_write_clk_n, en.bus_receive_en_n}));
		chk("rx", 8'ha5, rx);
		op(15'h4000, 1'b0, 1'b0, 8'h00);
		chk("port_rd", 8'h00, 8'(en.port_read_drive_n));
		op(15'h1fff, 1'b0, 1'b1, 8'h5a);
		chk("ctrl_mode", 8'h01, 8'(en.port_sel_n));
		$display("done t_mem");
	endtask : t_mem
	task automatic t_off();
		opt.no_rom = 1'b1;
		op(15'h0400, 1'b1, 1'b0, 8'h11);
		chk("no_rom", 8'h1f, 8'({oe_n, en.rom_ce_n}));
		{opt.no_rom, opt.no_ram} = 2'b01;
		op(15'h1010, 1'b1, 1'b0, 8'h22);
		chk("no_ram", 8'h03, 8'({en.ram_ce_n, en.ram_read_drive_n}));
		{opt.no_ram, opt.no_port} = 2'b01;
		op(15'h4000, 1'b0, 1'b1, 8'h33);
		chk("no_port", 8'h03, 8'({en.port_sel_n, en.port_write_clk_n}));
		op(15'h4000, 1'b0, 1'b0, 8'h33);
		chk("no_port_rd", 8'h01, 8'(en.port_read_drive_n));
		opt.no_port = 1'b0;
		// small arrangement picks the bank from one address bit only
		opt.rom_size_sel = 1'b1;
		op(15'h0c00, 1'b1, 1'b0, 8'h44);
		chk("rom_small", 8'h0d, 8'(en.rom_ce_n));
		opt.rom_size_sel = 1'b0;
		$display("done t_off");
	endtask : t_off
	task automatic t_pins();
		for (int i = 0; i < 8; i++) begin
			op({i[2:0], 12'h000}, 1'b1, 1'b0, 8'h00);
			chk("pin_ce_n", (i == 3) ? 8'hff : ~(8'h01 << i), pce_n);
			chk("pin_port_n", (i == 3) ? 8'hf7 : 8'hff, pps_n);
		end
		// function select off turns the role-switched pin back into a chip enable
		fs = 8'hf7;
		op(15'h3000, 1'b1, 1'b0, 8'h00);
		chk("pin_fs_ce", 8'hf7, pce_n);
		chk("pin_fs_port", 8'hff, pps_n);
		fs = 8'hff;
		$display("done t_pins");
	endtask : t_pins
	task automatic t_rst();
		int c;
		ext_rst = 1'b1;
		repeat (5) @(negedge core_clk);
		chk("ext_rst", 8'h01, 8'(sro));
		ext_rst = 1'b0;
		// RC and external with the option, RC without it, crystal last
		for (int s = 0; s < 4; s++) begin
			opt.osc_source = (s == 1) ? OSC_EXTERNAL : ((s == 3) ? OSC_CRYSTAL : OSC_RC);
			opt.por_enable = (s != 2);
			do_rst();
			c = 0;
			repeat (20) @(negedge core_clk) c += int'(poro === 1'b1);
			chk("por_len", (s < 2) ? 8'h04 : 8'h00, 8'(c));
		end
		ext_rst = 1'b1;
		repeat (5) @(negedge core_clk);
		chk("crystal_ext", 8'h01, 8'(sro));
		ext_rst = 1'b0;
		repeat (8) @(negedge core_clk);
		$display("done t_rst");
	endtask : t_rst
	task automatic t_div();
		int c;
		for (int r = 0; r < 4; r++) begin
			{opt.divider_select_high, opt.divider_select_low} = 2'(r);
			repeat (8) @(negedge core_clk);
			c = 0;
			repeat (24) @(negedge core_clk) c += int'(tick === 1'b1);
			chk("ticks", 8'(24 / (r + 1)), 8'(c));
		end
		$display("done t_div");
	endtask : t_div
	task automatic tally_and_finish();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		opt = '0;
		opt.osc_source = OSC_RC;
		opt.por_enable = 1'b1;
		do_rst();
		t_mem();
		t_off();
		t_pins();
		t_rst();
		t_div();
		tally_and_finish();
	end
endmodule : memory_interface_decode_bench
